//--- hdl/puc_regs.svh
`ifndef PUC_REGS_SVH
`define PUC_REGS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define PUC_CTRL_OFS     4'h0
`define PUC_STATUS_OFS   4'h4

// Reset value of the control byte: binary radix, counting up.
`define PUC_CTRL_RESET   8'h0C

// Status word fields.
`define PUC_STAT_CARRY   4

// Count limits of the two radices.
`define PUC_BIN_MAX      4'hF
`define PUC_DEC_MAX      4'h9
`define PUC_CNT_MIN      4'h0
`define PUC_CNT_ONE      4'h1

// AXI response codes.
`define PUC_RESP_OKAY    2'h0
`define PUC_RESP_SLVERR  2'h2

// Widths of the bus slice that is decoded.
`define PUC_AXI_AW       4

`endif

//--- hdl/puc_pkg.sv
package puc_pkg;

  // Control byte as software sees it; bit 0 is load_control.
  typedef struct packed {
    logic [3:0] load_data;
    logic       count_up;
    logic       radix_binary;
    logic       carry_in_n;
    logic       load_control;
  } puc_ctrl_s;

  // Read channel state.
  typedef enum logic [0:0] {
    PUC_RD_IDLE = 1'b0,
    PUC_RD_DATA = 1'b1
  } puc_rd_e;

  // Write channel state.
  typedef enum logic [0:0] {
    PUC_WR_IDLE = 1'b0,
    PUC_WR_RESP = 1'b1
  } puc_wr_e;

endpackage

//--- hdl/puc_counter.sv
// Functional notes
// - The counter keeps four state bits with four load inputs, four count outputs and a carry output whose look-ahead works in both radices.
// - While load_control is high the count follows the load inputs without waiting for a count clock edge.
// - Loading all-zero data with load_control high clears the count to zero.
// - A rising count clock edge steps the count by one only when carry_in_n and load_control are both low.
// - The count holds across count clock edges while carry_in_n or load_control is high.
// - The active-low carry output rests high and drops only while carry_in_n is low and the count sits at the terminal value of its direction.
// - Radix select high gives a sixteen-state binary sequence and low gives a ten-state decade sequence.
// - In decade mode the outputs present the count as a BCD digit.
// - Direction select high makes each step increment and low makes it decrement.
// - Counters cascade with a shared clock for synchronous outputs or in ripple fashion from the previous stage carry.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "puc_regs.svh"

module puc_counter
  import puc_pkg::*;
#(
  parameter int COUNT_W = 4
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   count_clk,
  input  wire logic                   cascade_carry_in_n,
  output logic [COUNT_W-1:0]          count_q,
  output logic                        carry_out_n,
  input  wire logic [`PUC_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`PUC_AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);

  // The stage logic is written for exactly four bits.
  if (COUNT_W != 4) begin : g_bad_width
    $error("puc_counter supports only COUNT_W of 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers: address decode shared by the read and write paths, and the count step.

  function automatic logic is_mapped(input logic [`PUC_AXI_AW-1:0] addr);
    if (addr == `PUC_CTRL_OFS) begin
      is_mapped = 1'b1;
    end else if (addr == `PUC_STATUS_OFS) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction

  // Next count for one step, with wrap-around in either radix.
  function automatic logic [3:0] step_value(input logic [3:0] cnt,
                                            input logic       up,
                                            input logic       binary);
    logic [3:0] top;
    top = binary ? `PUC_BIN_MAX : `PUC_DEC_MAX;
    if (up) begin
      // Out-of-range decade values left by a load also fold to zero.
      step_value = (cnt >= top) ? `PUC_CNT_MIN
                                : 4'(cnt + `PUC_CNT_ONE);
    end else begin
      step_value = (cnt == `PUC_CNT_MIN) ? top
                                         : 4'(cnt - `PUC_CNT_ONE);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The first stage feeds only the second.

  logic cclk_meta;
  logic cclk_sync;
  logic cclk_prev;
  logic cin_meta;
  logic cin_sync;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cclk_meta <= 1'b1;
      cclk_sync <= 1'b1;
      cclk_prev <= 1'b1;
      cin_meta  <= 1'b1;
      cin_sync  <= 1'b1;
    end else begin
      cclk_meta <= count_clk;
      cclk_sync <= cclk_meta;
      cclk_prev <= cclk_sync;
      cin_meta  <= cascade_carry_in_n;
      cin_sync  <= cin_meta;
    end
  end

  // Rising edge of the count clock, one system cycle wide.
  logic cclk_rise;
  assign cclk_rise = cclk_sync & ~cclk_prev;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path and control register.

  puc_wr_e    wr_state;
  puc_wr_e    next_wr_state;
  logic       aw_held;
  logic       next_aw_held;
  logic       w_held;
  logic       next_w_held;
  logic [3:0] aw_addr;
  logic [3:0] next_aw_addr;
  logic [7:0] w_byte;
  logic [7:0] next_w_byte;
  logic       w_lane0;
  logic       next_w_lane0;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  puc_ctrl_s  ctrl;
  puc_ctrl_s  next_ctrl;

  assign s_axi_awready = (wr_state == PUC_WR_IDLE) & ~aw_held;
  assign s_axi_wready  = (wr_state == PUC_WR_IDLE) & ~w_held;
  assign s_axi_bvalid  = (wr_state == PUC_WR_RESP);
  assign s_axi_bresp   = bresp;

  // Address and data are taken in either order; the write commits
  // once both are present, and the response waits for bready.
  always_comb begin
    logic aw_now;
    logic w_now;
    logic [3:0] addr_now;
    aw_now        = aw_held | (s_axi_awvalid & s_axi_awready);
    w_now         = w_held | (s_axi_wvalid & s_axi_wready);
    addr_now      = aw_held ? aw_addr : s_axi_awaddr;
    next_wr_state = wr_state;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_addr  = aw_addr;
    next_w_byte   = w_byte;
    next_w_lane0  = w_lane0;
    next_bresp    = bresp;
    next_ctrl     = ctrl;
    case (wr_state)
      PUC_WR_IDLE: begin
        if (s_axi_awvalid & s_axi_awready) begin
          next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          next_w_byte  = s_axi_wdata[7:0];
          next_w_lane0 = s_axi_wstrb[0];
        end
        if (aw_now & w_now) begin
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
          next_wr_state = PUC_WR_RESP;
          next_bresp    = is_mapped(addr_now) ? `PUC_RESP_OKAY
                                              : `PUC_RESP_SLVERR;
          if ((addr_now == `PUC_CTRL_OFS) &&
              (w_held ? w_lane0 : s_axi_wstrb[0])) begin
            next_ctrl = w_held ? w_byte : s_axi_wdata[7:0];
          end
        end else begin
          next_aw_held = aw_now;
          next_w_held  = w_now;
        end
      end
      PUC_WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = PUC_WR_IDLE;
        end
      end
      default: begin
        next_wr_state = PUC_WR_IDLE;
      end
    endcase
  end

  // Write channel registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_state <= PUC_WR_IDLE;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 4'h0;
      w_byte   <= 8'h00;
      w_lane0  <= 1'b0;
      bresp    <= `PUC_RESP_OKAY;
      ctrl     <= `PUC_CTRL_RESET;
    end else begin
      wr_state <= next_wr_state;
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      aw_addr  <= next_aw_addr;
      w_byte   <= next_w_byte;
      w_lane0  <= next_w_lane0;
      bresp    <= next_bresp;
      ctrl     <= next_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter core.

  logic [3:0] count;
  logic [3:0] next_count;
  logic       carry_n;
  logic       next_carry_n;

  // Carry-in from software and from a previous stage combine: either
  // one high inhibits, so an unused pin must sit low.
  logic       cin_n_eff;
  assign cin_n_eff = ctrl.carry_in_n | cin_sync;

  // Load has priority over counting and is re-applied every system
  // cycle, so the count tracks the load_data nibble while load stays high.
  always_comb begin
    logic [3:0] top;
    logic       cin_next;
    top        = next_ctrl.radix_binary ? `PUC_BIN_MAX : `PUC_DEC_MAX;
    // The synchronised pin is what the count path also obeys.
    cin_next   = next_ctrl.carry_in_n | cin_sync;
    next_count = count;
    if (next_ctrl.load_control) begin
      next_count = next_ctrl.load_data;
    end else if (cclk_rise && !cin_n_eff) begin
      next_count = step_value(count, ctrl.count_up,
                              ctrl.radix_binary);
    end else begin
      next_count = count;
    end
    // Look-ahead carry from the coming state so it lines up with it.
    next_carry_n = 1'b1;
    if (!cin_next) begin
      if (next_ctrl.count_up) begin
        next_carry_n = (next_count != top);
      end else begin
        next_carry_n = (next_count != `PUC_CNT_MIN);
      end
    end
  end

  // Count and carry registers drive the pins directly.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count   <= `PUC_CNT_MIN;
      carry_n <= 1'b1;
    end else begin
      count   <= next_count;
      carry_n <= next_carry_n;
    end
  end

  assign count_q     = count;
  assign carry_out_n = carry_n;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.

  puc_rd_e     rd_state;
  puc_rd_e     next_rd_state;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;

  assign s_axi_arready = (rd_state == PUC_RD_IDLE);
  assign s_axi_rvalid  = (rd_state == PUC_RD_DATA);
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // Read data is captured when the address is taken.
  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      PUC_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_rd_state = PUC_RD_DATA;
          next_rresp    = is_mapped(s_axi_araddr) ? `PUC_RESP_OKAY
                                                  : `PUC_RESP_SLVERR;
          if (s_axi_araddr == `PUC_CTRL_OFS) begin
            next_rdata = {24'h000000, ctrl};
          end else if (s_axi_araddr == `PUC_STATUS_OFS) begin
            next_rdata = 32'h00000000;
            next_rdata[3:0] = count;
            next_rdata[`PUC_STAT_CARRY] = carry_n;
          end else begin
            next_rdata = 32'h00000000;
          end
        end
      end
      PUC_RD_DATA: begin
        if (s_axi_rready) begin
          next_rd_state = PUC_RD_IDLE;
        end
      end
      default: begin
        next_rd_state = PUC_RD_IDLE;
      end
    endcase
  end

  // Read channel registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_state <= PUC_RD_IDLE;
      rdata    <= 32'h00000000;
      rresp    <= `PUC_RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

endmodule

//--- tb/puc_counter_asserts.sv
`timescale 1ns/1ns
module puc_counter_asserts
  import puc_pkg::*;
#(
  parameter int COUNT_W = 4
) (
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic               count_clk,
  input wire logic               cascade_carry_in_n,
  input wire logic [COUNT_W-1:0] count_q,
  input wire logic               carry_out_n,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] clk_hist;
  logic [7:0] next_clk_hist;
  logic       recent_rise;

  // Pin edges cross synchronisers, so a step is traced over a short history.
  always_comb begin
    next_clk_hist = {clk_hist[6:0], count_clk};
    recent_rise = |(clk_hist[6:0] & ~clk_hist[7:1]);
  end

  // History register only.
  always_ff @(posedge clk_sys) begin
    clk_hist <= next_clk_hist;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_inhibit;
    cascade_carry_in_n [*5];
  endsequence

  sequence s_step;
    $changed(count_q) && !$rose(s_axi_bvalid);
  endsequence

  a_count_cause: assert property ($changed(count_q) |->
    $rose(s_axi_bvalid) || recent_rise) else $error("Count moved alone.");
  a_step_one: assert property (s_step |->
    count_q == $past(count_q) + 4'h1
    || count_q == $past(count_q) - 4'h1 || count_q == 4'h0
    || count_q == 4'h9) else $error("Count step size wrong.");
  a_carry_term: assert property (!carry_out_n |->
    count_q inside {4'h0, 4'h9, 4'hF}) else $error("Carry off terminal.");
  a_carry_inhib: assert property (cascade_carry_in_n [*4] |->
    carry_out_n) else $error("Carry low while inhibited.");
  a_inhibit_hold: assert property (s_inhibit ##0 !$rose(s_axi_bvalid)
    |-> $stable(count_q)) else $error("Count moved while inhibited.");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("Write response late.");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("Read response late.");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped.");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address taken during answer.");
endmodule

bind puc_counter puc_counter_asserts #(.COUNT_W(COUNT_W)) chk_u (.*);

//--- tb/puc_ctl_model.sv
`timescale 1ns/1ns
module puc_ctl_model (
  input  wire logic clk_sys,
  output logic      count_clk,
  output logic      cascade_carry_in_n
);
  // Separate up and down strobes merge into the one count clock.
  logic strobe_up;
  logic strobe_dn;

  assign count_clk = strobe_up & strobe_dn;

  // Both strobes idle high, so the count clock rests high between
  // pulses and every direction write meets a high clock.
  // Inhibit stays low when not used.
  initial begin
    strobe_up          = 1'b1;
    strobe_dn          = 1'b1;
    cascade_carry_in_n = 1'b0;
  end

  // Three cycles low then high, above the two the synchronisers need;
  // the idle down strobe stays high while the up strobe pulses.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      strobe_up <= 1'b0;
      repeat (3) @(posedge clk_sys);
      strobe_up <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  // Counting inhibit from a preceding stage.
  task automatic inhibit(input logic v);
    @(posedge clk_sys);
    cascade_carry_in_n <= v;
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
`include "puc_regs.svh"
module tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        count_clk;
  logic        cascade_carry_in_n;
  logic [3:0]  count_q;
  logic        carry_out_n;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic [2:0]  s_axi_awprot = 3'h0;
  logic [2:0]  s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic        s_axi_rvalid;
  logic [1:0]  s_axi_bresp;
  logic [1:0]  s_axi_rresp;
  logic [1:0]  resp;
  logic [31:0] s_axi_rdata;
  logic [31:0] rd;
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #25 clk_sys = ~clk_sys;

  puc_ctl_model pm_u (.clk_sys(clk_sys), .count_clk(count_clk),
    .cascade_carry_in_n(cascade_carry_in_n));
  puc_counter dut_u (.*);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string       nm,
                     input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data offered together; each dropped once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Ready comes late on purpose so the slave has to hold its answer.
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic step(input int n, input logic [3:0] q, input logic c);
    pm_u.pulse(n);
    repeat (5) @(posedge clk_sys);
    chk("count_q", {28'h0, q}, {28'h0, count_q});
    chk("carry_out_n", {31'h0, c}, {31'h0, carry_out_n});
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles needed.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_reg(`PUC_STATUS_OFS);
    chk("status", 32'h10, rd);
    rd_reg(`PUC_CTRL_OFS);
    chk("ctrl", 32'h0C, rd);
    $display("test reset done");
    wr(`PUC_CTRL_OFS, 32'h7D);
    step(0, 4'h7, 1'b1);
    step(2, 4'h7, 1'b1);
    wr(`PUC_CTRL_OFS, 32'h0D);
    step(0, 4'h0, 1'b1);
    $display("test load done");
    wr(`PUC_CTRL_OFS, 32'hED);
    wr(`PUC_CTRL_OFS, 32'hEC);
    step(1, 4'hF, 1'b0);
    rd_reg(`PUC_STATUS_OFS);
    chk("status", 32'h0F, rd);
    step(1, 4'h0, 1'b1);
    $display("test binary up done");
    wr(`PUC_CTRL_OFS, 32'h11);
    wr(`PUC_CTRL_OFS, 32'h10);
    step(1, 4'h0, 1'b0);
    step(1, 4'h9, 1'b1);
    step(1, 4'h8, 1'b1);
    wr(`PUC_CTRL_OFS, 32'h89);
    wr(`PUC_CTRL_OFS, 32'h88);
    step(1, 4'h9, 1'b0);
    step(1, 4'h0, 1'b1);
    $display("test decade done");
    wr(`PUC_CTRL_OFS, 32'h99);
    wr(`PUC_CTRL_OFS, 32'h98);
    pm_u.inhibit(1'b1);
    step(2, 4'h9, 1'b1);
    pm_u.inhibit(1'b0);
    wr(`PUC_CTRL_OFS, 32'h9A);
    step(1, 4'h9, 1'b1);
    wr(`PUC_CTRL_OFS, 32'h98);
    step(1, 4'h0, 1'b1);
    $display("test inhibit done");
    wr(4'h8, 32'hFF);
    chk("bresp", {30'h0, `PUC_RESP_SLVERR}, {30'h0, resp});
    rd_reg(4'h8);
    chk("rresp", {30'h0, `PUC_RESP_SLVERR}, {30'h0, resp});
    chk("rdata", 32'h0, rd);
    step(0, 4'h0, 1'b1);
    $display("test unmapped done");
    print_verdict();
  end
endmodule
